// *** ocd_consts.svh ***
// Constants for the opcode decode and cycle-timing block.
// Assumes inclusion by bare name from the package and the decoder.
`ifndef OCD_CONSTS_SVH
`define OCD_CONSTS_SVH

// Prefix bytes that switch code pages
`define OCD_PFX_B          8'h42
`define OCD_PFX_X          8'h89

// Register indices on the plain register port
`define OCD_REG_STATUS     3'h0
`define OCD_REG_DPB        3'h1
`define OCD_REG_DBANK      3'h2
`define OCD_REG_PBANK      3'h3
`define OCD_REG_CYCLES     3'h4
`define OCD_REG_DECODE     3'h5

// Status word field positions
`define OCD_ST_C           0
`define OCD_ST_Z           1
`define OCD_ST_I           2
`define OCD_ST_D           3
`define OCD_ST_X           4
`define OCD_ST_M           5
`define OCD_ST_V           6
`define OCD_ST_N           7
`define OCD_ST_IPL_LO      8
`define OCD_ST_IPL_HI      10
`define OCD_ST_MASK        16'h07ff
`define OCD_ST_RESET       16'h0004

// Cycle figures
`define OCD_PUSH_BASE      20'h0000c
`define OCD_PUSH_WIDE      20'h00002
`define OCD_PUSH_BANK      20'h00001
`define OCD_PULL_BASE      20'h0000e
`define OCD_PULL_REG       20'h00003
`define OCD_PULL_DPB       20'h00004
`define OCD_MOVE_BASE      20'h00009
`define OCD_MOVE_STEP      20'h00007
`define OCD_MOVE_ODD       20'h00005
`define OCD_DIV_WIDE       20'h00010
`define OCD_MUL_WIDE       20'h00008
`define OCD_BRANCH_TAKEN   20'h00002
`define OCD_DP_PENALTY     20'h00001
`define OCD_CYC_SIMPLE     20'h00002
`define OCD_CYC_MEM        20'h00004
`define OCD_CYC_BRANCH     20'h00004
`define OCD_CYC_MUL        20'h00010
`define OCD_CYC_DIV        20'h00019
`define OCD_CYC_ROT        20'h00006

`endif

// *** ocd_pkg.sv ***
// Types for the opcode decode and cycle-timing block.
// Assumes the constants header sits in the same folder.
package ocd_pkg;
    `include "ocd_consts.svh"

    typedef enum logic [3:0] {
        OCD_UNDEF, OCD_ALU, OCD_IMM_ACC, OCD_IMM_IDX, OCD_BIT_MEM,
        OCD_BRANCH, OCD_PUSH, OCD_PULL, OCD_MOVE, OCD_MUL, OCD_DIV,
        OCD_SWAP, OCD_ROT, OCD_LDT, OCD_OTHER
    } ocd_class_t;

    typedef logic [19:0] ocd_cyc_t;

    typedef struct packed {
        logic [15:0] status;
        logic [15:0] dpb;
        logic [7:0]  dbank;
        logic [7:0]  pbank;
        logic [15:0] rdata;
        logic        dvalid;
        logic [1:0]  page;
        ocd_class_t  cls;
        logic        acc_b;
        logic [2:0]  len;
        ocd_cyc_t    cycles;
        logic        undef;
        logic [23:0] addr;
        logic [15:0] disp;
    } ocd_state_t;
endpackage

// *** ocd_decoder.sv ***
// Opcode decoder with instruction length and cycle-cost calculation.
// Assumes the fetch queue presents up to four bytes at once with a valid
// strobe, and that status/bank registers are written over the plain port.
//
// Chosen here: the register offsets and the strobed register port.
`include "ocd_consts.svh"

module ocd_decoder
    import ocd_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_srst,
    // Register port
    input  wire logic [2:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr_en,
    input  wire logic        i_rd_en,
    output logic      [15:0] o_rdata,
    // Instruction bytes from the fetch queue
    input  wire logic        i_dec_valid,
    input  wire logic [7:0]  i_op0,
    input  wire logic [7:0]  i_op1,
    input  wire logic [7:0]  i_op2,
    input  wire logic [7:0]  i_op3,
    // Execution conditions
    input  wire logic        i_taken,
    input  wire logic [15:0] i_move_count,
    input  wire logic [1:0]  i_queue_short,
    input  wire logic        i_addr_odd,
    input  wire logic        i_byte_bus,
    // Decode result
    output logic             o_dec_valid,
    output logic      [1:0]  o_page,
    output ocd_class_t       o_class,
    output logic             o_acc_b,
    output logic      [2:0]  o_length,
    output ocd_cyc_t         o_cycles,
    output logic             o_undefined,
    output logic      [23:0] o_addr24,
    output logic      [15:0] o_disp,
    output logic      [15:0] o_status
);

    ocd_state_t st;
    ocd_state_t next_st;

    logic       pfx;
    logic [7:0] code;
    logic [7:0] lo_b;
    logic [7:0] hi_b;
    logic [3:0] row;
    logic [3:0] col;
    logic       alu_col;
    logic       dir_mode;
    logic       flag_m;
    logic       flag_x;
    logic [2:0] len;
    ocd_class_t cls;
    ocd_cyc_t   base;
    ocd_cyc_t   total;
    ocd_cyc_t   n_wide;
    ocd_cyc_t   n_bank;
    ocd_cyc_t   n_pull;
    ocd_cyc_t   half;

    // Flags that steer operand length come straight from the status word
    assign flag_m = st.status[`OCD_ST_M];
    assign flag_x = st.status[`OCD_ST_X];

    // Byte selection: a prefix shifts the code and operands by one byte
    always_comb
    begin
        pfx  = (i_op0 == `OCD_PFX_B) || (i_op0 == `OCD_PFX_X);
        code = pfx ? i_op1 : i_op0;
        lo_b = pfx ? i_op2 : i_op1;
        hi_b = pfx ? i_op3 : i_op2;
        row  = code[7:4];
        col  = code[3:0];
        // Odd columns carry the accumulator forms; B and the blank 89 slot excluded
        alu_col = col[0] && (col != 4'hb) && !(row == 4'h8 && col == 4'h9);
    end

    // Class, length and base cost of the presented instruction
    always_comb
    begin
        cls      = OCD_OTHER;
        len      = 3'd1;
        base     = `OCD_CYC_SIMPLE;
        dir_mode = 1'b0;
        if (i_op0 == `OCD_PFX_X)
        begin
            // Multiply, divide and miscellaneous page
            cls = OCD_UNDEF;
            if ((alu_col || (col == 4'h2 && row[0])) && row <= 4'h3)
            begin
                cls  = row[1] ? OCD_DIV : OCD_MUL;
                base = row[1] ? `OCD_CYC_DIV : `OCD_CYC_MUL;
                // Operand bytes follow the accumulator forms of the plain page
                case (col)
                    4'h1, 4'h2, 4'h5, 4'h7:
                    begin
                        len      = 3'd2;
                        dir_mode = 1'b1;
                    end
                    4'h3:    len = 3'd2;
                    4'h9:    len = (row[0] || !flag_m) ? 3'd3 : 3'd2;
                    4'hd:    len = 3'd3;
                    default: len = 3'd4;
                endcase
            end
            else if (code == 8'h28)
            begin
                cls = OCD_SWAP;
            end
            else if (code == 8'h49)
            begin
                cls  = OCD_ROT;
                len  = flag_m ? 3'd2 : 3'd3;
                base = `OCD_CYC_ROT;
            end
            else if (code == 8'hc2)
            begin
                cls = OCD_LDT;
                len = 3'd2;
            end
        end
        else if (alu_col)
        begin
            // Accumulator operations on either page
            cls  = OCD_ALU;
            base = `OCD_CYC_MEM;
            case (col)
                4'h1, 4'h5, 4'h7:
                begin
                    len      = 3'd2;
                    dir_mode = 1'b1;
                end
                4'h3:    len = 3'd2;
                4'h9:    len = row[0] ? 3'd3 : 3'd2;
                4'hd:    len = 3'd3;
                4'hf:    len = 3'd4;
                default: len = 3'd1;
            endcase
            if (col == 4'h9 && !row[0])
            begin
                cls  = OCD_IMM_ACC;
                base = `OCD_CYC_SIMPLE;
                len  = flag_m ? 3'd2 : 3'd3;
            end
        end
        else if (i_op0 == `OCD_PFX_B)
        begin
            // B-specific transfers and the column-2 accumulator forms; every other slot here is blank
            case (code)
                8'h0a, 8'h1a, 8'h2a, 8'h3a, 8'h4a, 8'h6a, 8'h1b, 8'h3b,
                8'h5b, 8'h7b, 8'h48, 8'h68, 8'h8a, 8'h98, 8'ha8, 8'haa:
                    cls = OCD_OTHER;
                8'h12, 8'h32, 8'h52, 8'h72, 8'h92, 8'hb2, 8'hd2, 8'hf2:
                begin
                    cls      = OCD_ALU;
                    len      = 3'd2;
                    base     = `OCD_CYC_MEM;
                    dir_mode = 1'b1;
                end
                default:
                    cls = OCD_UNDEF;
            endcase
        end
        else
        begin
            // Unprefixed page, non-accumulator slots
            case (code)
                8'h12, 8'h32, 8'h52, 8'h72, 8'h92, 8'hb2, 8'hd2, 8'hf2:
                begin
                    cls      = OCD_ALU;
                    len      = 3'd2;
                    base     = `OCD_CYC_MEM;
                    dir_mode = 1'b1;
                end
                8'h10, 8'h30, 8'h50, 8'h70, 8'h80, 8'h90, 8'hb0, 8'hd0, 8'hf0:
                begin
                    cls  = OCD_BRANCH;
                    len  = 3'd2;
                    base = `OCD_CYC_BRANCH;
                end
                8'h82:
                begin
                    cls  = OCD_BRANCH;
                    len  = 3'd3;
                    base = `OCD_CYC_BRANCH;
                end
                8'ha0, 8'ha2, 8'hc0, 8'he0:
                begin
                    cls = OCD_IMM_IDX;
                    len = flag_x ? 3'd2 : 3'd3;
                end
                8'h04, 8'h14:
                begin
                    cls      = OCD_BIT_MEM;
                    len      = flag_m ? 3'd3 : 3'd4;
                    base     = `OCD_CYC_MEM;
                    dir_mode = 1'b1;
                end
                8'h24, 8'h34:
                begin
                    cls      = OCD_BIT_MEM;
                    len      = flag_m ? 3'd4 : 3'd5;
                    base     = `OCD_CYC_MEM;
                    dir_mode = 1'b1;
                end
                8'h0c, 8'h1c:
                begin
                    cls  = OCD_BIT_MEM;
                    len  = flag_m ? 3'd4 : 3'd5;
                    base = `OCD_CYC_MEM;
                end
                8'h2c, 8'h3c:
                begin
                    cls  = OCD_BIT_MEM;
                    len  = flag_m ? 3'd5 : 3'd6;
                    base = `OCD_CYC_MEM;
                end
                8'heb:
                begin
                    cls = OCD_PUSH;
                    len = 3'd2;
                end
                8'hfb:
                begin
                    cls = OCD_PULL;
                    len = 3'd2;
                end
                8'h44, 8'h54:
                begin
                    cls = OCD_MOVE;
                    len = 3'd3;
                end
                default:
                    cls = OCD_OTHER;
            endcase
        end
        if (pfx)
        begin
            len = len + 3'd1;
        end
    end

    // Register counts: mask bits 0-3 A,B,X,Y; 4 direct page; 5 data bank;
    // 6 program bank; 7 status
    always_comb
    begin
        n_wide = ocd_cyc_t'(lo_b[0]) + ocd_cyc_t'(lo_b[1]) + ocd_cyc_t'(lo_b[2])
               + ocd_cyc_t'(lo_b[3]) + ocd_cyc_t'(lo_b[4]) + ocd_cyc_t'(lo_b[7]);
        n_bank = ocd_cyc_t'(lo_b[5]) + ocd_cyc_t'(lo_b[6]);
        n_pull = ocd_cyc_t'(lo_b[0]) + ocd_cyc_t'(lo_b[1]) + ocd_cyc_t'(lo_b[2])
               + ocd_cyc_t'(lo_b[3]) + ocd_cyc_t'(lo_b[5]) + ocd_cyc_t'(lo_b[7]);
        half   = ocd_cyc_t'(i_move_count[15:1]);
    end

    // Cycle total: class cost, then the direct-page and bus adjustments
    always_comb
    begin
        case (cls)
            OCD_PUSH:   total = `OCD_PUSH_BASE + n_wide * `OCD_PUSH_WIDE
                              + n_bank * `OCD_PUSH_BANK;
            OCD_PULL:   total = `OCD_PULL_BASE + n_pull * `OCD_PULL_REG
                              + (lo_b[4] ? `OCD_PULL_DPB : 20'h00000);
            OCD_MOVE:   total = `OCD_MOVE_BASE + half * `OCD_MOVE_STEP
                              + (i_move_count[0] ? `OCD_MOVE_ODD : 20'h00000);
            OCD_MUL:    total = base + (flag_m ? 20'h00000 : `OCD_MUL_WIDE);
            OCD_DIV:    total = base + (flag_m ? 20'h00000 : `OCD_DIV_WIDE);
            OCD_BRANCH: total = base + (i_taken ? `OCD_BRANCH_TAKEN : 20'h00000);
            default:    total = base;
        endcase
        if (dir_mode && st.dpb[7:0] != 8'h00)
        begin
            total = total + `OCD_DP_PENALTY;
        end
        // Base figures assume a full queue, even address and word-wide bus
        total = total + ocd_cyc_t'(i_queue_short) + ocd_cyc_t'(i_addr_odd)
              + ocd_cyc_t'(i_byte_bus);
    end

    // Next-state: register port and the decode result latch
    always_comb
    begin
        next_st        = st;
        next_st.rdata  = 16'h0000;
        next_st.dvalid = 1'b0;
        if (i_wr_en)
        begin
            case (i_addr)
                `OCD_REG_STATUS: next_st.status = i_wdata & `OCD_ST_MASK;
                `OCD_REG_DPB:    next_st.dpb    = i_wdata;
                `OCD_REG_DBANK:  next_st.dbank  = i_wdata[7:0];
                `OCD_REG_PBANK:  next_st.pbank  = i_wdata[7:0];
                default:         next_st.dpb    = st.dpb;
            endcase
        end
        if (i_rd_en)
        begin
            case (i_addr)
                `OCD_REG_STATUS: next_st.rdata = st.status;
                `OCD_REG_DPB:    next_st.rdata = st.dpb;
                `OCD_REG_DBANK:  next_st.rdata = {8'h00, st.dbank};
                `OCD_REG_PBANK:  next_st.rdata = {8'h00, st.pbank};
                `OCD_REG_CYCLES: next_st.rdata = st.cycles[15:0];
                `OCD_REG_DECODE: next_st.rdata = {st.undef, st.acc_b, st.page,
                                                  1'b0, st.len, 4'h0, st.cls};
                default:         next_st.rdata = 16'h0000;
            endcase
        end
        if (i_dec_valid)
        begin
            next_st.dvalid = 1'b1;
            next_st.page   = (i_op0 == `OCD_PFX_B) ? 2'd1 :
                             (i_op0 == `OCD_PFX_X) ? 2'd2 : 2'd0;
            next_st.acc_b  = (i_op0 == `OCD_PFX_B);
            next_st.cls    = cls;
            next_st.len    = len;
            next_st.cycles = total;
            next_st.undef  = (cls == OCD_UNDEF);
            next_st.addr   = {st.dbank, hi_b, lo_b};
            // Short form sign-extends one byte, long form takes two
            next_st.disp   = (len == 3'd3) ? {hi_b, lo_b}
                                           : {{8{lo_b[7]}}, lo_b};
        end
    end

    // State register
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            st        <= '0;
            st.status <= `OCD_ST_RESET;
            st.cls    <= OCD_UNDEF;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs straight from flip-flops
    assign o_rdata     = st.rdata;
    assign o_dec_valid = st.dvalid;
    assign o_page      = st.page;
    assign o_class     = st.cls;
    assign o_acc_b     = st.acc_b;
    assign o_length    = st.len;
    assign o_cycles    = st.cycles;
    assign o_undefined = st.undef;
    assign o_addr24    = st.addr;
    assign o_disp      = st.disp;
    assign o_status    = st.status;

    // Checks on page selection, accumulator choice, immediate length, costs and status read
    chk_page_b_select: assert property (@(posedge i_clk) disable iff (i_srst)
        i_dec_valid && i_op0 == 8'h42 |=> o_page == 2'd1 && o_dec_valid)
        else $error("prefix 42 did not select page 1");
    chk_page_x_select: assert property (@(posedge i_clk) disable iff (i_srst)
        i_dec_valid && i_op0 == 8'h89 |=> o_page == 2'd2)
        else $error("prefix 89 did not select page 2");
    chk_acc_choice: assert property (@(posedge i_clk) disable iff (i_srst)
        i_dec_valid |=> o_acc_b == ($past(i_op0) == 8'h42))
        else $error("accumulator choice wrong");
    chk_imm_length: assert property (@(posedge i_clk) disable iff (i_srst)
        i_dec_valid && i_op0 == 8'ha9 && !flag_m && !i_wr_en |=> o_length == 3'd3)
        else $error("16-bit immediate length wrong");
    chk_branch_taken: assert property (@(posedge i_clk) disable iff (i_srst)
        i_dec_valid && i_op0 == 8'h80 && i_taken && i_queue_short == 2'd0
        && !i_addr_odd && !i_byte_bus |=> o_cycles == 20'd6)
        else $error("taken branch cost wrong");
    chk_push_cost: assert property (@(posedge i_clk) disable iff (i_srst)
        i_dec_valid && i_op0 == 8'heb && i_op1 == 8'h61 && i_queue_short == 2'd0
        && !i_addr_odd && !i_byte_bus |=> o_cycles == 20'd16)
        else $error("push cost wrong");
    chk_pull_cost: assert property (@(posedge i_clk) disable iff (i_srst)
        i_dec_valid && i_op0 == 8'hfb && i_op1 == 8'h11 && i_queue_short == 2'd0
        && !i_addr_odd && !i_byte_bus |=> o_cycles == 20'd21)
        else $error("pull cost wrong");
    chk_move_odd: assert property (@(posedge i_clk) disable iff (i_srst)
        i_dec_valid && i_op0 == 8'h54 && i_move_count == 16'h0005
        && i_queue_short == 2'd0 && !i_addr_odd && !i_byte_bus
        |=> o_cycles == 20'd28)
        else $error("odd block move cost wrong");
    chk_div_wide: assert property (@(posedge i_clk) disable iff (i_srst)
        i_dec_valid && i_op0 == 8'h89 && i_op1 == 8'h2d && !flag_m && !i_wr_en
        && i_queue_short == 2'd0 && !i_addr_odd && !i_byte_bus
        |=> o_cycles == `OCD_CYC_DIV + 20'd16)
        else $error("wide divide cost wrong");
    chk_read_latency: assert property (@(posedge i_clk) disable iff (i_srst)
        i_rd_en && i_addr == 3'h0 |=> o_rdata == $past(st.status))
        else $error("status read wrong");

endmodule // ocd_decoder

// *** ocd_fetch_model.sv ***
// Fetch-queue stand-in that hands instruction bytes and conditions over.
// Assumes the bench calls put() from one thread, one instruction at a time.
module ocd_fetch_model
(
    // Clock
    input  wire logic        i_clk,
    // Towards the decoder
    output logic             o_valid,
    output logic      [31:0] o_bytes,
    output logic      [20:0] o_cond
);
    timeunit 1ns;
    timeprecision 1ps;

    // Quiet queue at time zero
    initial
    begin
        o_valid = 1'b0;
        o_bytes = 32'h0;
        o_cond  = 21'h0;
    end

    // One instruction per call; the gap cycle keeps valid a clean pulse.
    // Released bytes turn to their inverse so a stale value never matches.
    task automatic put(input logic [31:0] b, input logic [20:0] c);
        @(posedge i_clk);
        o_valid <= 1'b1;
        o_bytes <= b;
        o_cond  <= c;
        @(posedge i_clk);
        o_valid <= 1'b0;
        o_bytes <= ~b;
    endtask
endmodule // ocd_fetch_model

// *** tb_cpu_opcode_decode_cycle_timing.sv ***
// Self-checking bench for the opcode decoder: register port and decode walks.
// Assumes ocd_pkg, ocd_decoder and ocd_fetch_model are compiled before it.
module tb_cpu_opcode_decode_cycle_timing
    import ocd_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        ocd_class_t  cls;
        logic [1:0]  pg;
        logic        ab;
        logic [3:0]  use_m;
        logic [2:0]  len;
        ocd_cyc_t    cyc;
        logic [15:0] dsp;
        logic [23:0] adr;
    } ocd_exp_t;

    logic        clk, srst, wr_en, rd_en, vld, rpend, dvalid, acc_b, undef;
    logic [2:0]  addr, len;
    logic [15:0] wdata, rdata, status, disp;
    logic [31:0] bytes;
    logic [20:0] cond;
    logic [1:0]  page;
    ocd_class_t  cls;
    ocd_cyc_t    cyc;
    logic [23:0] a24;
    logic [7:0]  dbank;
    int          fails, cmp_count, seed, k, n;
    ocd_exp_t    dq[$];
    logic [15:0] rq[$];

    ocd_fetch_model fq (.i_clk(clk), .o_valid(vld), .o_bytes(bytes), .o_cond(cond));

    ocd_decoder dut (
        .i_clk(clk), .i_srst(srst), .i_addr(addr), .i_wdata(wdata),
        .i_wr_en(wr_en), .i_rd_en(rd_en), .o_rdata(rdata),
        .i_dec_valid(vld), .i_op0(bytes[7:0]), .i_op1(bytes[15:8]),
        .i_op2(bytes[23:16]), .i_op3(bytes[31:24]), .i_taken(cond[20]),
        .i_move_count(cond[15:0]), .i_queue_short(cond[19:18]),
        .i_addr_odd(cond[17]), .i_byte_bus(cond[16]), .o_dec_valid(dvalid),
        .o_page(page), .o_class(cls), .o_acc_b(acc_b), .o_length(len),
        .o_cycles(cyc), .o_undefined(undef), .o_addr24(a24), .o_disp(disp),
        .o_status(status));

    // 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            fails++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic close_out;
        if (fails == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, input logic [15:0] e);
        @(posedge clk);
        rd_en <= 1'b1;
        addr  <= a;
        rq.push_back(e);
        @(posedge clk);
        rd_en <= 1'b0;
    endtask

    // Push and pull cost, worked out bit by bit from the register mask
    function automatic ocd_cyc_t cost(input logic [7:0] m, input logic pl);
        ocd_cyc_t s;
        s = pl ? 20'h0000e : 20'h0000c;
        for (int i = 0; i < 8; i++)
            if (m[i])
                s += pl ? ((i == 4) ? 4 : (i == 6) ? 0 : 3) : ((i == 5 || i == 6) ? 1 : 2);
        return s;
    endfunction

    // Note the expectation, then hand the bytes to the fetch model
    task automatic dec(input logic [31:0] b, input logic [20:0] c, input ocd_class_t t,
                       input logic [3:0] u, input logic [2:0] l, input ocd_cyc_t y);
        ocd_exp_t x;
        x.pg    = (b[7:0] == 8'h42) ? 2'h1 : (b[7:0] == 8'h89) ? 2'h2 : 2'h0;
        x.cls   = t;
        x.ab    = (x.pg == 2'h1);
        x.use_m = u;
        x.len   = l;
        x.cyc   = y + c[19:18] + c[17] + c[16];
        x.dsp   = (b[7:0] == 8'h82) ? b[23:8] : {{8{b[15]}}, b[15:8]};
        x.adr   = (x.pg != 2'h0) ? {dbank, b[31:16]} : {dbank, b[23:8]};
        dq.push_back(x);
        fq.put(b, c);
    endtask

    task automatic judge(input ocd_exp_t x);
        chk(32'({cls, page, undef}), 32'({x.cls, x.pg, x.cls == OCD_UNDEF}));
        if (x.pg != 2'h2 && x.cls != OCD_UNDEF) chk(32'(acc_b), 32'(x.ab));
        if (x.use_m[0]) chk(32'(len), 32'(x.len));
        if (x.use_m[1]) chk(32'(cyc), 32'(x.cyc));
        if (x.use_m[2]) chk(32'(disp), 32'(x.dsp));
        if (x.use_m[3]) chk(32'(a24), 32'(x.adr));
    endtask

    // Judged at the falling edge, clear of the edge that launches results
    always @(negedge clk)
    begin
        if (rpend)
            chk(32'(rdata), 32'(rq.pop_front()));
        rpend = rd_en;
        if (dvalid === 1'b1)
        begin
            chk(32'(dq.size() > 0), 32'h1);
            judge(dq.pop_front());
        end
    end

    // Main sequence
    initial
    begin
        seed = 90;
        srst = 1'b1;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 3'h0;
        wdata = 16'h0;
        rpend = 1'b0;
        dbank = 8'h0;
        fails = 0;
        cmp_count = 0;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        for (k = 0; k < 8; k++)
            rd(k[2:0], (k == 0) ? 16'h0004 : 16'h0000);
        chk(32'(status), 32'h0004);
        wr(3'h0, 16'hffff);
        wr(3'h4, 16'h1234);
        rd(3'h0, 16'h07ff);
        rd(3'h4, 16'h0000);
        chk(32'(status), 32'h07ff);
        dbank = 8'($random(seed));
        wr(3'h2, {8'h0, dbank});
        wr(3'h3, 16'h00a5);
        rd(3'h2, {8'h0, dbank});
        rd(3'h3, 16'h00a5);
        // Same codes in 8-bit, then 16-bit data and index widths
        for (k = 0; k < 2; k++)
        begin
            wr(3'h0, k ? 16'h0000 : 16'h0030);
            dec(32'h0000_00a9, 0, OCD_IMM_ACC, 4'h1, 3'(2 + k), 0);
            dec(32'h0000_0942, 0, OCD_IMM_ACC, 4'h1, 3'(3 + k), 0);
            dec(32'h0000_00a0, 0, OCD_IMM_IDX, 4'h1, 3'(2 + k), 0);
            dec(32'h0000_0004, 0, OCD_BIT_MEM, 4'h1, 3'(3 + k), 0);
            dec(32'h0000_4989, 0, OCD_ROT, 4'h1, 3'(3 + k), 0);
            dec(32'h0000_0989, 0, OCD_MUL, 4'h3, 3'(3 + k), 20'(16 + 8 * k));
            dec(32'h0000_2989, 0, OCD_DIV, 4'h3, 3'(3 + k), 20'(25 + 16 * k));
            dec(32'h0000_1289, 0, OCD_MUL, 4'h3, 3'h3, 20'(16 + 8 * k));
            dec(32'h0000_2d89, 0, OCD_DIV, 4'h3, 3'h4, 20'(25 + 16 * k));
        end
        dec(32'h0000_2889, 0, OCD_SWAP, 4'h0, 0, 0);
        dec(32'h0000_c289, 0, OCD_LDT, 4'h0, 0, 0);
        dec(32'h0000_0042, 0, OCD_UNDEF, 4'h0, 0, 0);
        dec(32'h0000_5089, 0, OCD_UNDEF, 4'h0, 0, 0);
        // Every conditional branch row, taken or not at random
        for (k = 1; k < 16; k += 2)
        begin
            n = $random(seed);
            dec({16'h0, n[7:0], 4'(k), 4'h0}, {n[8], 20'h0}, OCD_BRANCH, 4'h7, 3'h2,
                20'(4 + 2 * n[8]));
        end
        dec({16'h0, n[7:0], 8'h80}, {1'b1, 20'h0}, OCD_BRANCH, 4'h7, 3'h2, 20'd6);
        n = $random(seed);
        dec({8'h0, n[15:0], 8'h82}, 0, OCD_BRANCH, 4'h5, 3'h3, 0);
        dec(32'h0080_0082, 0, OCD_BRANCH, 4'h5, 3'h3, 0);
        // Push and pull masks: random, then empty and full
        for (k = 0; k < 6; k++)
        begin
            n = (k > 3) ? -(k & 1) : $random(seed);
            dec({16'h0, n[7:0], k[0] ? 8'hfb : 8'heb}, 0, k[0] ? OCD_PULL : OCD_PUSH, 4'h3,
                3'h2, cost(n[7:0], k[0]));
        end
        // Both block moves with even and odd counts
        for (k = 0; k < 4; k++)
        begin
            n = $random(seed);
            dec({24'h0, k[1] ? 8'h54 : 8'h44}, {5'h0, n[15:1], k[0]}, OCD_MOVE, 4'h2, 0,
                20'(9 + 7 * n[15:1] + 5 * k[0]));
        end
        // Fixed masks and counts worked out by hand from the per-register costs
        dec(32'h0000_61eb, 0, OCD_PUSH, 4'h3, 3'h2, 20'd16);
        dec(32'h0000_11fb, 0, OCD_PULL, 4'h3, 3'h2, 20'd21);
        dec(32'h0000_0054, 21'h000005, OCD_MOVE, 4'h2, 0, 20'd28);
        // Only a nonzero low byte of the page base costs the extra cycle
        for (k = 0; k < 3; k++)
        begin
            wr(3'h1, (k == 1) ? 16'h0100 : {15'h0, k == 2});
            n = $random(seed);
            dec({8'h0, n[15:0], 8'h05}, 0, OCD_ALU, 4'ha, 0, 20'(4 + (k == 2)));
        end
        dec(32'h0000_00eb, 21'h0f0000, OCD_PUSH, 4'h2, 0, 20'h0000c);
        repeat (4) @(posedge clk);
        chk(32'(dq.size() + rq.size()), 32'h0);
        close_out;
    end

    // Whole run needs under two microseconds; a hang is cut well beyond that
    initial
    begin
        #50us;
        fails++;
        close_out;
    end
endmodule // tb_cpu_opcode_decode_cycle_timing
